// *** lpts_regs.svh ***
// Register offsets, field positions, reset values and bus codes for the LPC target front end
`ifndef LPTS_REGS_SVH
`define LPTS_REGS_SVH

// ==========================================================================
// AXI4-Lite register map (byte addresses)
`define LPTS_LOCK_OFS       8'h00
`define LPTS_WAIT_OFS       8'h04
`define LPTS_GPI_OFS        8'h08
`define LPTS_STATUS_OFS     8'h0c
`define LPTS_LOCK_RST       8'h00
`define LPTS_WAIT_RST       4'h2

// ==========================================================================
// Status register fields
`define LPTS_ST_AAMUX_BIT   0
`define LPTS_ST_BUSY_BIT    1
`define LPTS_ST_BLOCKED_BIT 2
`define LPTS_ST_READ_BIT    3
`define LPTS_ST_CNT_LSB     8

// ==========================================================================
// LPC field codes
`define LPTS_START          4'h0
`define LPTS_SYNC_READY     4'h0
`define LPTS_SYNC_WAIT      4'h5
`define LPTS_TAR_DRIVE      4'hf
`define LPTS_CYC_MEM        2'b01
`define LPTS_ADDR_NIBBLES   3'h7
`define LPTS_TOP_HIGH       8'hff
`define LPTS_BOTTOM_HIGH    8'h00
`define LPTS_TOP_BLOCK      3'h7
`define LPTS_GPI_REG_ADDR   19'h00100
`define LPTS_UNMAPPED_BYTE  8'hff

// ==========================================================================
// AXI responses
`define LPTS_RESP_OKAY      2'b00
`define LPTS_RESP_SLVERR    2'b10

`endif

// *** lpts_pkg.sv ***
// Types shared by the LPC target front end
package lpts_pkg;

  // ==========================================================================
  // Port sequencer states
  typedef enum logic [3:0] {
    LPTS_IDLE,
    LPTS_CYC,
    LPTS_ADDR,
    LPTS_WDATA,
    LPTS_TAR1,
    LPTS_TAR2,
    LPTS_SYNC,
    LPTS_RDATA,
    LPTS_TARE,
    LPTS_SKIP
  } lpts_state_e;

endpackage

// *** lpts_top.sv ***
// LPC target port front end: framing, chip select, window decode, protection, AXI4-Lite registers
// Contract
// - Frame low at a rising edge starts a new transaction.
// - Frame low during a transaction abandons it.
// - Frame high means continue current transaction or stay idle.
// - Address, data and control move as 4-bit nibbles on LAD both ways.
// - Respond only when A22..A19 matches the four strap inputs.
// - Top expects inverted strap; bottom expects strap with bit 0 inverted.
// - Top window A23 high is array; bottom window A23 low is array.
// - General input pin levels are readable through a general input register.
// - Interface select sampled only during reset, then held fixed.
// - Interface select low uses LPC port; high selects the alternate port.
// - Interface reset low holds reset with LAD released.
// - After reset release the device is in array read mode.
// - CPU reset acts like interface reset; either low resets.
// - LAD is sampled and driven synchronous to the bus clock.
// - Top block lock low blocks program and erase of block 7.
// - Top block lock high defers to lock register; never touches blocks 0-6.
// - Main write protect low blocks program and erase of blocks 0-6.
// - Main write protect high defers to lock register; never touches block 7.
// - A18..A0 form the byte address inside a selected window.
// - Read drives sync until waits end, then data low nibble first.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lpts_regs.svh"

module lpts_top #(
  parameter int GPI_WIDTH = 5,
  parameter int BLOCKS    = 8
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // LPC pins
  input  wire logic [3:0]  lad_in,
  output logic [3:0]       lad_out,
  output logic             lad_oe,
  input  wire logic        lframe_n,
  input  wire logic        interface_reset_n,
  input  wire logic        cpu_reset_n,
  // Straps and general inputs
  input  wire logic [3:0]  chip_id_strap,
  input  wire logic [4:0]  general_input,
  input  wire logic        interface_select,
  input  wire logic        top_block_lock_n,
  input  wire logic        main_write_protect_n,
  input  wire logic        reserved_pin,
  // Array core port
  output logic [18:0]      array_addr,
  output logic             array_rd,
  output logic             array_prog,
  output logic [7:0]       array_wdata,
  input  wire logic [7:0]  array_rdata,
  // Mode
  output logic             aamux_mode,
  output logic             array_read_mode
);

  // ==========================================================================
  // Elaboration checks
  if (GPI_WIDTH != 5 || BLOCKS != 8) begin : g_chk
    $error("lpts_top serves five general inputs and eight blocks only");
  end

  // ==========================================================================
  // Helpers
  function automatic logic is_blocked(input logic [2:0] blk, input logic [7:0] lock,
                                      input logic tbl_n, input logic wp_n);
    if (blk == `LPTS_TOP_BLOCK) begin
      is_blocked = !tbl_n || lock[blk];
    end else begin
      is_blocked = !wp_n || lock[blk];
    end
  endfunction

  // ==========================================================================
  // Reset and mode
  logic rst_int;
  logic unused_pin;
  assign rst_int    = !aresetn || !interface_reset_n || !cpu_reset_n;
  assign unused_pin = reserved_pin;

  always_ff @(posedge aclk) begin
    if (rst_int) begin
      aamux_mode <= interface_select;
    end
  end

  // ==========================================================================
  // General input register
  logic [4:0] gpi_q;
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      gpi_q <= 5'h00;
    end else begin
      gpi_q <= general_input;
    end
  end

  // ==========================================================================
  // Software registers
  logic [7:0]  lock_q;
  logic [3:0]  wait_q;
  logic        blocked_q;
  logic [7:0]  blocked_cnt_q;
  logic        read_mode_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // ==========================================================================
  // Port sequencer
  lpts_pkg::lpts_state_e state_q;
  lpts_pkg::lpts_state_e state_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic [31:0] addr_q;
  logic        dir_wr_q;
  logic        in_array_q;
  logic [7:0]  wbyte_q;
  logic [7:0]  rbyte_q;
  logic [7:0]  rd_byte;
  logic        top_hit;
  logic        bot_hit;
  logic        sel_array;
  logic [31:0] addr_full;

  assign addr_full = {addr_q[27:0], lad_in};
  assign top_hit = addr_full[31:24] == `LPTS_TOP_HIGH && addr_full[22:19] == ~chip_id_strap;
  assign bot_hit = addr_full[31:24] == `LPTS_BOTTOM_HIGH &&
                   addr_full[22:19] == {chip_id_strap[3:1], ~chip_id_strap[0]};
  assign sel_array = top_hit ? addr_full[23] : ~addr_full[23];
  assign rd_byte = in_array_q ? array_rdata :
                   (addr_q[18:0] == `LPTS_GPI_REG_ADDR) ? {3'h0, gpi_q} : `LPTS_UNMAPPED_BYTE;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (aamux_mode) begin
      state_d = lpts_pkg::LPTS_IDLE;
    end else if (!lframe_n) begin
      state_d = (lad_in == `LPTS_START) ? lpts_pkg::LPTS_CYC : lpts_pkg::LPTS_IDLE;
      cnt_d   = 3'h0;
    end else begin
      case (state_q)
        lpts_pkg::LPTS_IDLE: begin
          state_d = lpts_pkg::LPTS_IDLE;
        end
        lpts_pkg::LPTS_CYC: begin
          state_d = (lad_in[3:2] == `LPTS_CYC_MEM) ? lpts_pkg::LPTS_ADDR : lpts_pkg::LPTS_SKIP;
          cnt_d   = 3'h0;
        end
        lpts_pkg::LPTS_ADDR: begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `LPTS_ADDR_NIBBLES) begin
            if (!(top_hit || bot_hit)) begin
              state_d = lpts_pkg::LPTS_SKIP;
            end else begin
              state_d = dir_wr_q ? lpts_pkg::LPTS_WDATA : lpts_pkg::LPTS_TAR1;
            end
            cnt_d = 3'h0;
          end
        end
        lpts_pkg::LPTS_WDATA: begin
          cnt_d = 3'h1;
          if (cnt_q == 3'h1) begin
            state_d = lpts_pkg::LPTS_TAR1;
            cnt_d   = 3'h0;
          end
        end
        lpts_pkg::LPTS_TAR1: begin
          state_d = lpts_pkg::LPTS_TAR2;
        end
        lpts_pkg::LPTS_TAR2: begin
          state_d = lpts_pkg::LPTS_SYNC;
          cnt_d   = dir_wr_q ? 3'h0 : wait_q[2:0];
        end
        lpts_pkg::LPTS_SYNC: begin
          if (cnt_q == 3'h0) begin
            state_d = dir_wr_q ? lpts_pkg::LPTS_TARE : lpts_pkg::LPTS_RDATA;
          end else begin
            cnt_d = cnt_q - 3'h1;
          end
        end
        lpts_pkg::LPTS_RDATA: begin
          cnt_d = 3'h1;
          if (cnt_q == 3'h1) begin
            state_d = lpts_pkg::LPTS_TARE;
            cnt_d   = 3'h0;
          end
        end
        lpts_pkg::LPTS_TARE: begin
          state_d = lpts_pkg::LPTS_IDLE;
        end
        lpts_pkg::LPTS_SKIP: begin
          state_d = lpts_pkg::LPTS_SKIP;
        end
        default: begin
          state_d = lpts_pkg::LPTS_IDLE;
        end
      endcase
    end
  end

  // State and counters
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      state_q <= lpts_pkg::LPTS_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Field capture
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      addr_q     <= 32'h0;
      dir_wr_q   <= 1'b0;
      in_array_q <= 1'b0;
      wbyte_q    <= 8'h00;
    end else begin
      if (state_q == lpts_pkg::LPTS_CYC && lframe_n) begin
        dir_wr_q <= lad_in[1];
      end
      if (state_q == lpts_pkg::LPTS_ADDR && lframe_n) begin
        addr_q <= addr_full;
        if (cnt_q == `LPTS_ADDR_NIBBLES) begin
          in_array_q <= sel_array;
        end
      end
      if (state_q == lpts_pkg::LPTS_WDATA && lframe_n) begin
        if (cnt_q == 3'h0) begin
          wbyte_q[3:0] <= lad_in;
        end else begin
          wbyte_q[7:4] <= lad_in;
        end
      end
    end
  end

  // LAD drive
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      lad_oe  <= 1'b0;
      lad_out <= 4'h0;
      rbyte_q <= 8'h00;
    end else begin
      lad_oe  <= state_d == lpts_pkg::LPTS_SYNC || state_d == lpts_pkg::LPTS_RDATA ||
                 state_d == lpts_pkg::LPTS_TARE;
      lad_out <= 4'h0;
      case (state_d)
        lpts_pkg::LPTS_SYNC: begin
          lad_out <= (cnt_d != 3'h0) ? `LPTS_SYNC_WAIT : `LPTS_SYNC_READY;
        end
        lpts_pkg::LPTS_RDATA: begin
          if (cnt_d == 3'h0) begin
            lad_out <= rd_byte[3:0];
            rbyte_q <= rd_byte;
          end else begin
            lad_out <= rbyte_q[7:4];
          end
        end
        lpts_pkg::LPTS_TARE: begin
          lad_out <= `LPTS_TAR_DRIVE;
        end
        default: begin
          lad_out <= 4'h0;
        end
      endcase
    end
  end

  // Array core requests
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      array_addr    <= 19'h0;
      array_rd      <= 1'b0;
      array_prog    <= 1'b0;
      array_wdata   <= 8'h00;
      blocked_q     <= 1'b0;
      blocked_cnt_q <= 8'h00;
    end else begin
      array_rd   <= 1'b0;
      array_prog <= 1'b0;
      if (state_q == lpts_pkg::LPTS_TAR2 && state_d == lpts_pkg::LPTS_SYNC && in_array_q) begin
        array_addr <= addr_q[18:0];
        if (!dir_wr_q) begin
          array_rd <= 1'b1;
        end else if (is_blocked(addr_q[18:16], lock_q, top_block_lock_n, main_write_protect_n)) begin
          blocked_q     <= 1'b1;
          blocked_cnt_q <= blocked_cnt_q + 8'h01;
        end else begin
          array_prog  <= 1'b1;
          array_wdata <= wbyte_q;
          blocked_q   <= 1'b0;
        end
      end
    end
  end

  // Mode flag
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      read_mode_q <= 1'b1;
    end else if (array_prog) begin
      read_mode_q <= 1'b0;
    end else if (state_q == lpts_pkg::LPTS_IDLE) begin
      read_mode_q <= 1'b1;
    end
  end
  assign array_read_mode = read_mode_q;

  // ==========================================================================
  // AXI4-Lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LPTS_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      lock_q        <= `LPTS_LOCK_RST;
      wait_q        <= `LPTS_WAIT_RST;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got_q && !s_axi_bvalid;
      s_axi_wready  <= !s_axi_wready && s_axi_wvalid && !w_got_q && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LPTS_RESP_OKAY;
        case (awaddr_q)
          `LPTS_LOCK_OFS: begin
            if (wstrb_q[0]) begin
              lock_q <= wdata_q[7:0];
            end
          end
          `LPTS_WAIT_OFS: begin
            if (wstrb_q[0]) begin
              wait_q <= {1'b0, wdata_q[2:0]};
            end
          end
          `LPTS_GPI_OFS, `LPTS_STATUS_OFS: begin
            s_axi_bresp <= `LPTS_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `LPTS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `LPTS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `LPTS_RESP_OKAY;
        s_axi_rdata  <= 32'h0;
        case (s_axi_araddr)
          `LPTS_LOCK_OFS: begin
            s_axi_rdata <= {24'h0, lock_q};
          end
          `LPTS_WAIT_OFS: begin
            s_axi_rdata <= {28'h0, wait_q};
          end
          `LPTS_GPI_OFS: begin
            s_axi_rdata <= {27'h0, gpi_q};
          end
          `LPTS_STATUS_OFS: begin
            s_axi_rdata[`LPTS_ST_AAMUX_BIT]   <= aamux_mode;
            s_axi_rdata[`LPTS_ST_BUSY_BIT]    <= state_q != lpts_pkg::LPTS_IDLE;
            s_axi_rdata[`LPTS_ST_BLOCKED_BIT] <= blocked_q;
            s_axi_rdata[`LPTS_ST_READ_BIT]    <= read_mode_q;
            s_axi_rdata[`LPTS_ST_CNT_LSB +: 8] <= blocked_cnt_q;
          end
          default: begin
            s_axi_rresp <= `LPTS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** lpts_chk.sv ***
// Assertion checker for the LPC target front end
`timescale 1ns/1ns
module lpts_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // LPC pins
  input wire logic [3:0]  lad_out,
  input wire logic        lad_oe,
  input wire logic        lframe_n,
  input wire logic        interface_reset_n,
  input wire logic        cpu_reset_n,
  // Protection inputs and array port
  input wire logic        top_block_lock_n,
  input wire logic        main_write_protect_n,
  input wire logic [18:0] array_addr,
  input wire logic        array_rd,
  input wire logic        array_prog,
  // Mode
  input wire logic        aamux_mode,
  input wire logic        array_read_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Assertions
  a_pin_reset_quiet: assert property (!interface_reset_n |=> !lad_oe && array_read_mode)
    else $error("LAD driven during interface reset");
  a_cpu_reset_same: assert property (!cpu_reset_n |=> !lad_oe && array_read_mode)
    else $error("LAD driven during cpu reset");
  a_frame_quiet: assert property (!lframe_n |-> ##2 !lad_oe [*8])
    else $error("LAD driven while host sends a frame");
  a_alt_port_off: assert property (aamux_mode |-> !lad_oe)
    else $error("LAD driven with alternate port chosen");
  a_select_frozen: assert property ($past(aresetn) && $past(interface_reset_n) && $past(cpu_reset_n)
                                    |-> $stable(aamux_mode))
    else $error("Interface choice changed outside reset");
  a_top_lock_hold: assert property (array_prog && array_addr[18:16] == 3'h7 |-> top_block_lock_n)
    else $error("Top block programmed while locked");
  a_main_wp_hold: assert property (array_prog && array_addr[18:16] != 3'h7 |-> main_write_protect_n)
    else $error("Main block programmed while protected");
  a_read_sync_first: assert property (array_rd |-> lad_oe && (lad_out == 4'h5 || lad_out == 4'h0))
    else $error("Read does not open with a sync nibble");
  a_drive_tail_ones: assert property ($fell(lad_oe) && $past(lframe_n) && $past(lframe_n, 2) &&
                                      $past(interface_reset_n) && $past(cpu_reset_n) |-> $past(lad_out) == 4'hf)
    else $error("LAD released without turnaround ones");

  // ==========================================================================
  // Coverage
  c_prog: cover property (array_prog);
  c_read: cover property (array_rd);
  c_alt: cover property (aamux_mode && interface_reset_n);
endmodule

bind lpts_top lpts_chk lpts_chk_i (.aclk, .aresetn, .lad_out, .lad_oe, .lframe_n, .interface_reset_n, .cpu_reset_n,
  .top_block_lock_n, .main_write_protect_n, .array_addr, .array_rd, .array_prog, .aamux_mode, .array_read_mode);

// *** lpts_host.sv ***
// LPC host controller model driving frames into the target
`timescale 1ns/1ns
module lpts_host (
  // Clock
  input wire logic       clk,
  // Resolved LAD lines, frame and host drive
  input wire logic [3:0] lad,
  output logic           lframe_n,
  output logic [3:0]     host_lad,
  output logic           host_oe
);
  initial begin
    lframe_n = 1'b1;
    host_lad = 4'hf;
    host_oe  = 1'b0;
  end

  // ==========================================================================
  // One memory cycle; nonzero cut stops after that many address nibbles
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] wd, input int cut,
                      output logic ok, output logic [7:0] rd, output int waits);
    int i;
    ok = 1'b0;
    rd = 8'h00;
    waits = 0;
    @(posedge clk);
    lframe_n <= 1'b0;
    host_lad <= 4'h0;
    host_oe  <= 1'b1;
    @(posedge clk);
    lframe_n <= 1'b1;
    host_lad <= {2'b01, wr, 1'b0};
    for (i = 7; i >= 0; i--) begin
      @(posedge clk);
      host_lad <= a[i*4 +: 4];
      if (cut == 8 - i) return;
    end
    if (wr) begin
      @(posedge clk);
      host_lad <= wd[3:0];
      @(posedge clk);
      host_lad <= wd[7:4];
    end
    @(posedge clk);
    host_lad <= 4'hf;
    @(posedge clk);
    host_oe <= 1'b0;
    for (i = 0; i < 48 && !ok; i++) begin
      @(posedge clk);
      if (lad === 4'h5) waits++;
      ok = (lad === 4'h0);
    end
    if (ok && !wr) begin
      @(posedge clk);
      rd[3:0] = lad;
      @(posedge clk);
      rd[7:4] = lad;
    end
    repeat (2) @(posedge clk);
  endtask
endmodule

// *** lpc_target_select_protect_test.sv ***
// Testbench for the LPC target front end
`timescale 1ns/1ns
`include "lpts_regs.svh"
module lpc_target_select_protect_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lad_oe, lframe_n, host_oe, reserved_pin;
  logic        interface_reset_n, cpu_reset_n, interface_select, top_block_lock_n, main_write_protect_n;
  logic        array_rd, array_prog, aamux_mode, array_read_mode, ok;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb, lad_out, lad, host_lad, chip_id_strap;
  logic [4:0]  general_input;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, array_wdata, array_rdata, prog_d, rd;
  logic [18:0] array_addr, prog_a;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int          bad_count, total_checks, prog_n, w;

  // ==========================================================================
  // Pull-ups on LAD, array core model, program monitor
  assign lad = lad_oe ? lad_out : (host_oe ? host_lad : 4'hf);
  assign array_rdata = array_addr[7:0] ^ 8'h5a;
  always @(posedge aclk) begin
    if (array_prog === 1'b1) begin
      prog_n <= prog_n + 1;
      prog_a <= array_addr;
      prog_d <= array_wdata;
    end
  end

  lpts_top lpts_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lad_in(lad), .lad_out, .lad_oe,
    .lframe_n, .interface_reset_n, .cpu_reset_n, .chip_id_strap, .general_input, .interface_select,
    .top_block_lock_n, .main_write_protect_n, .reserved_pin, .array_addr, .array_rd, .array_prog, .array_wdata,
    .array_rdata, .aamux_mode, .array_read_mode);
  lpts_host lpts_host_i (.clk(aclk), .lad, .lframe_n, .host_lad, .host_oe);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================================
  // Reporting and bus tasks
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    bad_count++;
    $display("wrong value at %0t: timeout", $time);
    stop_test;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dw);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) timeout;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) timeout;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic rdx(input logic [31:0] a);
    lpts_host_i.xfer(1'b0, a, 8'h00, 0, ok, rd, w);
  endtask
  task automatic t_reset;
    chk(array_read_mode, 1, "read mode");
    chk(lad_oe, 0, "lad released");
    axi_rd(`LPTS_WAIT_OFS);
    chk(d, 2, "wait reset");
    axi_rd(8'h10);
    chk(r, `LPTS_RESP_SLVERR, "unmapped read");
    axi_wr(8'h14, 32'h1);
    chk(r, `LPTS_RESP_SLVERR, "unmapped write");
    axi_rd(`LPTS_GPI_OFS);
    chk(d, {27'h0, general_input}, "gpi over axi");
  endtask
  task automatic t_select;
    logic [3:0]  s;
    logic [18:0] a;
    for (int i = 0; i < 16; i++) begin
      s = 4'(i);
      a = {s, 15'h1234};
      chip_id_strap <= s;
      general_input <= 5'(i * 3);
      reserved_pin <= s[1];
      rdx({8'hff, 1'b1, ~s, a});
      chk(ok, 1, "top select");
      chk(rd, 8'h6e, "top data");
      chk(w, 2, "wait syncs");
      rdx({8'h00, 1'b0, s[3:1], ~s[0], a});
      chk(rd, 8'h6e, "bottom data");
      rdx({8'hff, 1'b0, ~s, `LPTS_GPI_REG_ADDR});
      chk(rd, {3'b0, general_input}, "top gpi");
      rdx({8'h00, 1'b1, s[3:1], ~s[0], `LPTS_GPI_REG_ADDR});
      chk(rd, {3'b0, general_input}, "bottom gpi");
      rdx({8'hff, 1'b1, s, a});
      chk(ok, 0, "foreign strap");
    end
  endtask
  task automatic t_protect;
    logic [13:0] tab [8];
    int          n;
    tab = '{{2'b11, 8'h00, 3'h7, 1'b1}, {2'b01, 8'h00, 3'h7, 1'b0}, {2'b01, 8'h00, 3'h6, 1'b1},
            {2'b10, 8'h00, 3'h0, 1'b0}, {2'b10, 8'h00, 3'h7, 1'b1}, {2'b11, 8'h80, 3'h7, 1'b0},
            {2'b11, 8'h01, 3'h0, 1'b0}, {2'b11, 8'h01, 3'h1, 1'b1}};
    chip_id_strap <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      top_block_lock_n <= tab[i][13];
      main_write_protect_n <= tab[i][12];
      axi_wr(`LPTS_LOCK_OFS, {24'h0, tab[i][11:4]});
      n = prog_n;
      lpts_host_i.xfer(1'b1, {8'hff, 1'b1, 4'hf, tab[i][3:1], 16'h0abc}, 8'ha6 ^ 8'(i), 0, ok, rd, w);
      chk(ok, 1, "write sync");
      chk(prog_n - n, 32'(tab[i][0]), "program count");
      if (tab[i][0]) begin
        chk(prog_a, {tab[i][3:1], 16'h0abc}, "prog addr");
        chk(prog_d, 8'ha6 ^ 8'(i), "prog data");
      end
    end
    axi_rd(`LPTS_STATUS_OFS);
    chk(d[15:8], 8'h04, "blocked count");
  endtask
  task automatic t_wait;
    int wv [3];
    wv = '{5, 0, 7};
    for (int i = 0; i < 3; i++) begin
      axi_wr(`LPTS_WAIT_OFS, 32'(wv[i]));
      rdx(32'hfffa345a);
      chk(w, wv[i], "wait count");
      chk(rd, 8'h00, "wait data");
    end
    axi_wr(`LPTS_WAIT_OFS, 32'h2);
  endtask
  task automatic t_abort;
    int n;
    n = prog_n;
    lpts_host_i.xfer(1'b1, 32'hfffa0011, 8'h77, 3, ok, rd, w);
    rdx(32'hfffa00c4);
    chk(rd, 8'h9e, "abort read");
    chk(prog_n - n, 0, "abort drop");
  endtask
  task automatic t_pin_reset;
    interface_reset_n <= 1'b0;
    rdx(32'hfff80001);
    chk(ok, 0, "rp silent");
    interface_reset_n <= 1'b1;
    cpu_reset_n <= 1'b0;
    rdx(32'hfff80001);
    chk(ok, 0, "cpu silent");
    cpu_reset_n <= 1'b1;
    rdx(32'hfff80001);
    chk(rd, 8'h5b, "pin reset read");
    chk(array_read_mode, 1, "read mode");
  endtask
  task automatic t_ifsel;
    interface_select <= 1'b1;
    do_reset;
    chk(aamux_mode, 1, "alt chosen");
    rdx(32'hfff80001);
    chk(ok, 0, "lpc off");
    interface_select <= 1'b0;
    axi_rd(`LPTS_STATUS_OFS);
    chk(d[0], 1, "choice kept");
    do_reset;
    chk(aamux_mode, 0, "LPC chosen");
    interface_select <= 1'b1;
    rdx(32'hfff80001);
    chk(ok, 1, "lpc kept");
    chk(aamux_mode, 0, "mode frozen");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, interface_select, reserved_pin} = '0;
    {interface_reset_n, cpu_reset_n, top_block_lock_n, main_write_protect_n} = 4'hf;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    chip_id_strap = 4'h0;
    general_input = 5'h15;
    aresetn = 1'b0;
    do_reset;
    t_reset;
    t_select;
    t_protect;
    t_wait;
    t_abort;
    t_pin_reset;
    t_ifsel;
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    timeout;
  end
endmodule
